// File: logic/bram_fifo_defines.svh
// Register offsets, reset values and field positions of the memory block.
// Assumes inclusion by the block's design file and by its bench.
`ifndef BRAM_FIFO_DEFINES_SVH
`define BRAM_FIFO_DEFINES_SVH

// ====================================================================
// Register offsets
`define CTRL_OFFSET 8'h00
`define THRESH_OFFSET 8'h04
`define DEPTH_OFFSET 8'h08
`define STATUS_OFFSET 8'h0C

// ====================================================================
// Reset values
`define CTRL_RESET 32'h0000_0000
`define AFULL_THR_RESET 9'h010
`define AEMPTY_THR_RESET 9'h010
`define DEPTH_RESET 10'h200

// ====================================================================
// Field positions
`define THR_AFULL_LSB 0
`define THR_AEMPTY_LSB 16
`define STAT_EMPTY_BIT 16

// ====================================================================
// Bus answers
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2

`endif

// File: logic/bram_fifo_pkg.sv
// Types of the dual-port memory block with its queue controller.
// Assumes nothing of its surroundings.
package bram_fifo_pkg;

  // ==================================================================
  // Port widths and write behaviour
  typedef enum logic [2:0] {
    W1 = 3'h0, W2 = 3'h1, W4 = 3'h2, W9 = 3'h3, W18 = 3'h4, W36 = 3'h5, W72 = 3'h6
  } width_e;

  typedef enum logic [1:0] {
    WRITE_FIRST = 2'h0, READ_FIRST = 2'h1, NO_CHANGE = 2'h2
  } wmode_e;

  // ==================================================================
  // Control word, one port request, whole state
  typedef struct packed {
    logic [12:0] rsvd;
    logic fwft;
    logic fifo_en;
    logic ecc_en;
    logic casc_upper;
    logic casc_en;
    logic half_split;
    logic split_read_write_mode;
    logic outreg_b;
    logic outreg_a;
    wmode_e wmode_b;
    wmode_e wmode_a;
    width_e width_b;
    width_e width_a;
  } ctrl_s;

  typedef struct packed {
    logic en;
    logic [7:0] we;
    logic [15:0] addr;
    logic [71:0] din;
  } port_req_s;

  typedef struct packed {
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    ctrl_s ctrl;
    logic [8:0] afull_thr;
    logic [8:0] aempty_thr;
    logic [9:0] depth;
    logic [1:0][71:0] raw;
    logic [1:0][71:0] dout;
    logic [1:0] casc;
    logic b_sbit;
    logic b_dbit;
    logic [8:0] wptr;
    logic [8:0] rptr;
    logic [9:0] count;
    logic fwft_valid;
    logic [71:0] f_dout;
    logic f_full;
    logic f_empty;
    logic f_afull;
    logic f_aempty;
    logic [7:0] enc_check;
    logic [63:0] dec_data;
    logic dec_sbit;
    logic dec_dbit;
  } state_s;

endpackage

// File: logic/dual_port_block_ram_fifo.sv
// Dual-port memory block with width modes, check-bit coding and a queue controller.
// Assumes one clock for both ports and the bus, and user logic on both ports.
//
// Summary of operation
// RULE1 - Two independent access ports that share only the stored contents.
// RULE2 - All reads and writes, their inputs and enables, act on a clock edge.
// RULE3 - Address is registered; output data holds until the next port operation.
// RULE4 - Optional output register adds one cycle of read latency.
// RULE5 - During writes output shows old data, new data, or holds.
// RULE6 - Port widths 1, 2, 4, 9, 18, 36 and 72 bits with matching depths.
// RULE7 - The two ports choose their widths independently.
// RULE8 - Block splits into two independent halves with the same behaviour.
// RULE9 - Widths above 18 or 36 bits only in split read/write mode.
// RULE10 - In that mode one side is variable, the other fixed wide.
// RULE11 - In full true dual-port operation both ports pick variable widths.
// RULE12 - Two neighbouring blocks join into one single-bit deep memory.
// RULE13 - Eight check bits per 64-bit word; fix single, flag double errors.
// RULE14 - Check-bit encoder and decoder are usable standalone.
// RULE15 - Queue controller steps its own read and write addresses.
// RULE16 - Queue drives full, empty, almost full and almost empty flags.
// RULE17 - Almost-full and almost-empty thresholds are programmable.
// RULE18 - Queue depth programmable; write and read widths are always equal.
// RULE19 - Fall-through mode shows the first word before any read.
// RULE20 - After the first read, fall-through behaves like the standard mode.
// RULE21 - Byte-lane write enables update only the selected bytes; with check bits on at 72 bits the whole word is written.
// RULE22 - Write when full or read when empty is ignored entirely.
`include "bram_fifo_defines.svh"

module dual_port_block_ram_fifo (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire bram_fifo_pkg::port_req_s a_req,
  input wire bram_fifo_pkg::port_req_s b_req,
  output logic [71:0] a_dout,
  output logic [71:0] b_dout,
  output logic b_sbiterr,
  output logic b_dbiterr,
  input wire logic [1:0] cascade_din,
  output logic [1:0] cascade_dout,
  input wire logic fifo_wr_en,
  input wire logic [71:0] fifo_din,
  input wire logic fifo_rd_en,
  output logic [71:0] fifo_dout,
  output logic fifo_full,
  output logic fifo_empty,
  output logic fifo_afull,
  output logic fifo_aempty,
  input wire logic [63:0] ecc_enc_data,
  output logic [7:0] ecc_enc_check,
  input wire logic [71:0] ecc_dec_word,
  output logic [63:0] ecc_dec_data,
  output logic ecc_dec_sbit,
  output logic ecc_dec_dbit
);

  // ==================================================================
  // Helper functions
  function automatic int lane_log(input bram_fifo_pkg::width_e w);
    case (w)
      bram_fifo_pkg::W1: return 6;
      bram_fifo_pkg::W2: return 5;
      bram_fifo_pkg::W4: return 4;
      bram_fifo_pkg::W9: return 3;
      bram_fifo_pkg::W18: return 2;
      bram_fifo_pkg::W36: return 1;
      default: return 0;
    endcase
  endfunction

  function automatic int wbits(input bram_fifo_pkg::width_e w);
    case (w)
      bram_fifo_pkg::W1: return 1;
      bram_fifo_pkg::W2: return 2;
      bram_fifo_pkg::W4: return 4;
      bram_fifo_pkg::W9: return 9;
      bram_fifo_pkg::W18: return 18;
      bram_fifo_pkg::W36: return 36;
      default: return 72;
    endcase
  endfunction

  function automatic bram_fifo_pkg::width_e eff_width(input bram_fifo_pkg::width_e w, input logic srw,
                                                      input logic half);
    bram_fifo_pkg::width_e mx;
    mx = half ? (srw ? bram_fifo_pkg::W36 : bram_fifo_pkg::W18) : (srw ? bram_fifo_pkg::W72 : bram_fifo_pkg::W36);
    return (w > mx) ? mx : w;
  endfunction

  function automatic logic [8:0] word_of(input logic [15:0] addr, input bram_fifo_pkg::width_e w,
                                         input logic half_sel, input logic half);
    logic [14:0] a;
    a = addr[14:0] >> lane_log(w);
    return half ? {half_sel, a[7:0]} : a[8:0];
  endfunction

  function automatic logic [5:0] lane_of(input logic [15:0] addr, input bram_fifo_pkg::width_e w);
    logic [5:0] m;
    m = 6'((1 << lane_log(w)) - 1);
    return addr[5:0] & m;
  endfunction

  function automatic logic [71:0] merge(input logic [71:0] old, input logic [71:0] din,
                                        input bram_fifo_pkg::width_e w, input logic [5:0] lane,
                                        input logic [7:0] we);
    logic [71:0] r;
    int wb;
    int base;
    int j;
    r = old;
    wb = wbits(w);
    base = int'(lane) * wb;
    for (int i = 0; i < 72; i++) begin
      j = i - base;
      if (j >= 0 && j < wb && (wb >= 18 ? we[j / 9] : we[0])) begin
        r[i] = din[j];
      end
    end
    return r;
  endfunction

  function automatic logic [71:0] extract(input logic [71:0] word, input bram_fifo_pkg::width_e w,
                                          input logic [5:0] lane);
    logic [71:0] r;
    int wb;
    int base;
    r = '0;
    wb = wbits(w);
    base = int'(lane) * wb;
    for (int j = 0; j < 72; j++) begin
      if (j < wb && base + j < 72) begin
        r[j] = word[base + j];
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] ham_enc(input logic [63:0] d);
    logic [71:1] cw;
    logic [7:0] c;
    int k;
    cw = '0;
    c = '0;
    k = 0;
    for (int p = 1; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        cw[p] = d[k];
        k++;
      end
    end
    for (int b = 0; b < 7; b++) begin
      for (int p = 1; p < 72; p++) begin
        if (((p >> b) & 1) == 1) begin
          c[b] = c[b] ^ cw[p];
        end
      end
    end
    c[7] = ^{c[6:0], d};
    return c;
  endfunction

  function automatic logic [65:0] ham_dec(input logic [71:0] w);
    logic [7:0] c;
    logic [6:0] syn;
    logic par;
    logic [63:0] d;
    int k;
    d = w[63:0];
    c = ham_enc(d);
    syn = c[6:0] ^ w[70:64];
    par = ^w;
    k = 0;
    for (int p = 1; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (par && syn == 7'(p)) begin
          d[k] = ~d[k];
        end
        k++;
      end
    end
    return {d, par, (syn != 7'h00) && !par};
  endfunction

  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8 * i +: 8] = nw[8 * i +: 8];
      end
    end
    return r;
  endfunction

  // ==================================================================
  // Storage and state
  logic [71:0] mem [0:511];
  bram_fifo_pkg::state_s st;
  bram_fifo_pkg::state_s nx;
  bram_fifo_pkg::port_req_s rq [2];
  bram_fifo_pkg::width_e pw [2];
  logic [1:0] hit;
  logic [1:0] act;
  logic [1:0] wr;
  logic [1:0] rd;
  logic [8:0] wd [2];
  logic [5:0] ln [2];
  logic [71:0] old [2];
  logic [71:0] nw [2];
  logic [71:0] rdw [2];
  logic [31:0] thw;
  logic [65:0] decb;
  logic fw;
  logic pop;

  // ==================================================================
  // Port address, width and write data
  always_comb begin
    rq[0] = a_req;
    rq[1] = b_req;
    pw[0] = eff_width(st.ctrl.width_a, st.ctrl.split_read_write_mode, st.ctrl.half_split); // RULE9
    pw[1] = eff_width(st.ctrl.width_b, st.ctrl.split_read_write_mode, st.ctrl.half_split); // RULE7
    if (st.ctrl.split_read_write_mode && pw[0] != bram_fifo_pkg::W36 && pw[0] != bram_fifo_pkg::W72) begin
      pw[1] = st.ctrl.half_split ? bram_fifo_pkg::W36 : bram_fifo_pkg::W72; // RULE10
    end
    for (int i = 0; i < 2; i++) begin
      hit[i] = !st.ctrl.casc_en || rq[i].addr[15] == st.ctrl.casc_upper; // RULE12
      act[i] = aresetn && rq[i].en && !st.ctrl.fifo_en && hit[i]; // RULE1
      wr[i] = act[i] && |rq[i].we && !(st.ctrl.split_read_write_mode && i == 1); // RULE9
      rd[i] = act[i] && !(st.ctrl.split_read_write_mode && i == 0);
      wd[i] = word_of(rq[i].addr, pw[i], i[0], st.ctrl.half_split); // RULE8 RULE6
      ln[i] = lane_of(rq[i].addr, pw[i]);
      old[i] = mem[wd[i]];
      rdw[i] = extract(old[i], pw[i], ln[i]);
      if (st.ctrl.ecc_en && pw[i] == bram_fifo_pkg::W72) begin
        nw[i] = {ham_enc(rq[i].din[63:0]), rq[i].din[63:0]}; // RULE13
      end else begin
        nw[i] = merge(old[i], rq[i].din, pw[i], ln[i], rq[i].we); // RULE21
      end
    end
    decb = ham_dec(old[1]);
  end

  // ==================================================================
  // Next state
  always_comb begin
    nx = st;
    // Memory ports
    for (int i = 0; i < 2; i++) begin
      if (rd[i]) begin
        nx.casc[i] = rdw[i][0];
        if (wr[i] && (i == 0 ? st.ctrl.wmode_a : st.ctrl.wmode_b) == bram_fifo_pkg::WRITE_FIRST) begin
          nx.raw[i] = extract(nw[i], pw[i], ln[i]); // RULE5
        end else if (!wr[i] || (i == 0 ? st.ctrl.wmode_a : st.ctrl.wmode_b) == bram_fifo_pkg::READ_FIRST) begin
          nx.raw[i] = rdw[i]; // RULE5
        end
      end else if (rq[i].en && !st.ctrl.fifo_en && !hit[i]) begin
        nx.raw[i] = {71'h0, cascade_din[i]}; // RULE12
      end
    end
    if (rd[1] && !wr[1] && st.ctrl.ecc_en && pw[1] == bram_fifo_pkg::W72) begin
      nx.raw[1] = {8'h00, decb[65:2]}; // RULE13
      nx.b_sbit = decb[1];
      nx.b_dbit = decb[0];
    end else if (rd[1]) begin
      nx.b_sbit = 1'b0;
      nx.b_dbit = 1'b0;
    end
    nx.dout[0] = st.ctrl.outreg_a ? st.raw[0] : nx.raw[0]; // RULE4 RULE3
    nx.dout[1] = st.ctrl.outreg_b ? st.raw[1] : nx.raw[1]; // RULE4
    // Queue controller, one word width both sides
    fw = aresetn && st.ctrl.fifo_en && fifo_wr_en && st.count != st.depth; // RULE22 RULE18
    pop = st.ctrl.fifo_en && st.count != 10'h000 &&
          (st.ctrl.fwft ? (!st.fwft_valid || fifo_rd_en) : fifo_rd_en); // RULE22 RULE19 RULE20
    if (fw) begin
      nx.wptr = ({1'b0, st.wptr} == st.depth - 10'h001) ? 9'h000 : st.wptr + 9'h001; // RULE15
    end
    if (pop) begin
      nx.f_dout = mem[st.rptr];
      nx.rptr = ({1'b0, st.rptr} == st.depth - 10'h001) ? 9'h000 : st.rptr + 9'h001; // RULE15
    end
    if (st.ctrl.fwft) begin
      nx.fwft_valid = pop ? 1'b1 : (fifo_rd_en ? 1'b0 : st.fwft_valid); // RULE19
    end else begin
      nx.fwft_valid = 1'b0;
    end
    nx.count = st.count + {9'h000, fw} - {9'h000, pop};
    nx.f_empty = st.ctrl.fwft ? !nx.fwft_valid : nx.count == 10'h000; // RULE16
    // Standalone check-bit coding
    nx.enc_check = ham_enc(ecc_enc_data); // RULE14
    {nx.dec_data, nx.dec_sbit, nx.dec_dbit} = ham_dec(ecc_dec_word); // RULE14
    // Register bus writes
    if (st.bvalid && bready) begin
      nx.bvalid = 1'b0;
    end
    if (awvalid && st.awready) begin
      nx.aw_got = 1'b1;
      nx.awaddr = awaddr;
    end
    if (wvalid && st.wready) begin
      nx.w_got = 1'b1;
      nx.wdata = wdata;
      nx.wstrb = wstrb;
    end
    thw = apply_strb({7'h00, st.aempty_thr, 7'h00, st.afull_thr}, nx.wdata, nx.wstrb);
    if (nx.aw_got && nx.w_got && !st.bvalid) begin
      nx.aw_got = 1'b0;
      nx.w_got = 1'b0;
      nx.bvalid = 1'b1;
      nx.bresp = `AXI_OKAY;
      if (nx.awaddr == `CTRL_OFFSET) begin
        nx.ctrl = apply_strb(st.ctrl, nx.wdata, nx.wstrb);
      end else if (nx.awaddr == `THRESH_OFFSET) begin
        nx.afull_thr = thw[`THR_AFULL_LSB +: 9]; // RULE17
        nx.aempty_thr = thw[`THR_AEMPTY_LSB +: 9]; // RULE17
      end else if (nx.awaddr == `DEPTH_OFFSET) begin
        if (nx.wdata[9:0] != 10'h000 && nx.wdata[9:0] <= `DEPTH_RESET && nx.wstrb[1:0] == 2'h3) begin
          nx.depth = nx.wdata[9:0]; // RULE18
        end
      end else if (nx.awaddr != `STATUS_OFFSET) begin
        nx.bresp = `AXI_SLVERR;
      end
    end
    nx.awready = !nx.aw_got && !nx.bvalid;
    nx.wready = !nx.w_got && !nx.bvalid;
    // Queue level flags against the current settings
    nx.f_full = nx.count == nx.depth; // RULE16
    nx.f_afull = ({1'b0, nx.count} + {2'h0, nx.afull_thr}) >= {1'b0, nx.depth}; // RULE17
    nx.f_aempty = nx.count <= {1'b0, nx.aempty_thr}; // RULE17
    // Register bus reads
    if (st.rvalid && rready) begin
      nx.rvalid = 1'b0;
    end
    if (arvalid && st.arready) begin
      nx.rvalid = 1'b1;
      nx.rresp = `AXI_OKAY;
      if (araddr == `CTRL_OFFSET) begin
        nx.rdata = st.ctrl;
      end else if (araddr == `THRESH_OFFSET) begin
        nx.rdata = {7'h00, st.aempty_thr, 7'h00, st.afull_thr};
      end else if (araddr == `DEPTH_OFFSET) begin
        nx.rdata = {22'h000000, st.depth};
      end else if (araddr == `STATUS_OFFSET) begin
        nx.rdata = {12'h000, st.f_aempty, st.f_afull, st.f_full, st.f_empty, 6'h00, st.count};
      end else begin
        nx.rdata = 32'h0000_0000;
        nx.rresp = `AXI_SLVERR;
      end
    end
    nx.arready = !nx.rvalid;
    // Synchronous reset
    if (!aresetn) begin
      nx = '0;
      nx.ctrl = `CTRL_RESET;
      nx.afull_thr = `AFULL_THR_RESET;
      nx.aempty_thr = `AEMPTY_THR_RESET;
      nx.depth = `DEPTH_RESET;
      nx.awready = 1'b1;
      nx.wready = 1'b1;
      nx.arready = 1'b1;
      nx.f_empty = 1'b1;
      nx.f_aempty = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    st <= nx; // RULE2
  end

  // ==================================================================
  // Memory writes, port B after port A
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 2; i++) begin
      if (wr[i]) begin
        mem[wd[i]] <= nw[i]; // RULE2 RULE11
      end
    end
    if (fw) begin
      mem[st.wptr] <= fifo_din;
    end
  end

  // ==================================================================
  // Outputs
  assign awready = st.awready;
  assign wready = st.wready;
  assign bresp = st.bresp;
  assign bvalid = st.bvalid;
  assign arready = st.arready;
  assign rdata = st.rdata;
  assign rresp = st.rresp;
  assign rvalid = st.rvalid;
  assign a_dout = st.dout[0];
  assign b_dout = st.dout[1];
  assign b_sbiterr = st.b_sbit;
  assign b_dbiterr = st.b_dbit;
  assign cascade_dout = st.casc;
  assign fifo_dout = st.f_dout;
  assign fifo_full = st.f_full;
  assign fifo_empty = st.f_empty;
  assign fifo_afull = st.f_afull;
  assign fifo_aempty = st.f_aempty;
  assign ecc_enc_check = st.enc_check;
  assign ecc_dec_data = st.dec_data;
  assign ecc_dec_sbit = st.dec_sbit;
  assign ecc_dec_dbit = st.dec_dbit;

  // ==================================================================
  // Assertions
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_port_a_idle;
    !a_req.en ##1 !a_req.en;
  endsequence

  sequence s_outreg_a_held;
    st.ctrl.outreg_a ##1 st.ctrl.outreg_a;
  endsequence

  a_dout_hold: assert property (s_port_a_idle |=> $stable(a_dout)) // RULE3
    else $error("port A output changed without an operation");
  a_out_stage: assert property (s_outreg_a_held |-> a_dout == $past(st.raw[0])) // RULE4
    else $error("output register stage not one cycle behind");
  a_srw_no_write: assert property (st.ctrl.split_read_write_mode |-> !wr[1]) // RULE9
    else $error("read-only port wrote in split read/write mode");
  a_full_ignored: assert property (fifo_full && fifo_wr_en && !fifo_rd_en |=> $stable(st.wptr) && $stable(st.count)) // RULE22
    else $error("write accepted while full");
  a_empty_ignored: assert property (st.count == 10'h000 && fifo_rd_en |=> $stable(st.rptr)) // RULE22
    else $error("read accepted while empty");
  a_wptr_step: assert property (fw && {1'b0, st.wptr} + 10'h001 < st.depth |=> st.wptr == $past(st.wptr) + 9'h001) // RULE15
    else $error("write pointer did not step by one");
  a_afull_flag: assert property (##1 fifo_afull == (({1'b0, st.count} + {2'h0, st.afull_thr}) >= {1'b0, st.depth})) // RULE17
    else $error("almost full flag does not match fill level");
  a_fwft_show: assert property (st.ctrl.fifo_en && st.ctrl.fwft && !st.fwft_valid && st.count != 10'h000 |=> !fifo_empty) // RULE19
    else $error("first word not presented");
  a_ecc_flags: assert property (!(ecc_dec_sbit && ecc_dec_dbit)) // RULE13
    else $error("single and double error flagged together");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");

endmodule

// File: tb/queue_user.sv
// Model of the user logic on the queue's write and read side.
// Assumes bench commands that change just after a rising edge.
module queue_user (
  input wire logic aclk,
  input wire logic push,
  input wire logic pop,
  input wire logic [71:0] data,
  output logic fifo_wr_en,
  output logic [71:0] fifo_din,
  output logic fifo_rd_en
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==================================================================
  // Requests one edge after the command; idle data toggles
  initial begin
    fifo_wr_en = 1'b0;
    fifo_rd_en = 1'b0;
    fifo_din = 72'h0;
  end
  always @(posedge aclk) begin
    fifo_wr_en <= push;
    fifo_rd_en <= pop;
    fifo_din <= push ? data : ~fifo_din;
  end
endmodule

// File: tb/dual_port_block_ram_fifo_test.sv
// Self-checking bench of the memory block and its queue.
// Assumes the design package and a single 20 MHz clock.
`include "bram_fifo_defines.svh"
module dual_port_block_ram_fifo_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, seed = 32'h3126;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, b_sbiterr, b_dbiterr, ecc_dec_sbit, ecc_dec_dbit;
  logic fifo_wr_en, fifo_rd_en, fifo_full, fifo_empty, fifo_afull, fifo_aempty;
  logic [1:0] bresp, rresp, cascade_dout;
  logic [1:0] cascade_din = 2'h0;
  bram_fifo_pkg::port_req_s a_req = '0, b_req = '0;
  logic [71:0] a_dout, b_dout, fifo_dout, fifo_din;
  logic [71:0] ecc_dec_word = 72'h0, data = 72'h0;
  logic [63:0] ecc_enc_data = 64'h0, ecc_dec_data;
  logic [7:0] ecc_enc_check;
  logic push = 1'b0, pop = 1'b0, due = 1'b0, sel = 1'b0, fq = 1'b0;
  logic [1:0] pend = 2'h0;
  logic [71:0] exp_q[$];
  logic [71:0] mem[5];
  int bad_count = 0;
  int num_checks = 0;

  dual_port_block_ram_fifo DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .a_req(a_req), .b_req(b_req), .a_dout(a_dout),
    .b_dout(b_dout), .b_sbiterr(b_sbiterr), .b_dbiterr(b_dbiterr), .cascade_din(cascade_din),
    .cascade_dout(cascade_dout), .fifo_wr_en(fifo_wr_en), .fifo_din(fifo_din), .fifo_rd_en(fifo_rd_en),
    .fifo_dout(fifo_dout), .fifo_full(fifo_full), .fifo_empty(fifo_empty), .fifo_afull(fifo_afull),
    .fifo_aempty(fifo_aempty), .ecc_enc_data(ecc_enc_data), .ecc_enc_check(ecc_enc_check),
    .ecc_dec_word(ecc_dec_word), .ecc_dec_data(ecc_dec_data), .ecc_dec_sbit(ecc_dec_sbit),
    .ecc_dec_dbit(ecc_dec_dbit));
  queue_user partner (.aclk(aclk), .push(push), .pop(pop), .data(data), .fifo_wr_en(fifo_wr_en),
    .fifo_din(fifo_din), .fifo_rd_en(fifo_rd_en));

  // ==================================================================
  // Clock, helpers and result watcher
  initial begin
    forever #25 aclk = ~aclk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string n, input logic [71:0] e, input logic [71:0] s);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", 72'(`AXI_OKAY), 72'(bresp));
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    exp_q.push_back(72'(e));
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk("rresp", 72'(r), 72'(rresp));
    @(posedge aclk);
  endtask
  always @(posedge aclk) pend <= {pend[0], due};
  always @(negedge aclk) begin
    if ((rvalid && rready) || pend[sel]) begin
      if (rvalid) chk("rdata", exp_q.size() ? exp_q.pop_front() : 72'hX, 72'(rdata));
      else if (fq) chk("fifo_dout", exp_q.pop_front(), fifo_dout);
      else chk("b_dout", exp_q.pop_front(), b_dout);
    end
  end
  initial begin
    #(50 * 4000);
    bad_count++;
    report_and_stop();
  end

  // ==================================================================
  // Scenarios
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h04, 32'h0010_0010, `AXI_OKAY);
    rd(8'h08, 32'h0000_0200, `AXI_OKAY);
    rd(8'h0C, 32'h0009_0000, `AXI_OKAY);
    rd(8'h10, 32'h0, `AXI_SLVERR);
    for (int ob = 0; ob < 2; ob++) begin
      sel = ob[0];
      wr(8'h00, 32'h2D | (ob << 11), 4'hF);
      for (int i = 0; i < 4; i++) begin
        mem[i] = {36'h0, 4'(xs()), xs()};
        @(posedge aclk);
        a_req <= '{1'b1, 8'h0F, 16'(i), mem[i]};
      end
      @(posedge aclk);
      a_req <= '{1'b1, 8'h01, 16'h0, {72{1'b1}}};
      mem[0][8:0] = 9'h1FF;
      @(posedge aclk);
      a_req <= '0;
      @(negedge aclk);
      chk("a_dout", mem[0], a_dout);
      for (int i = 0; i < 4; i++) begin
        @(posedge aclk);
        b_req <= '{1'b1, 8'h00, 16'(i), 72'h0};
        due <= 1'b1;
        exp_q.push_back(mem[i]);
      end
      @(posedge aclk);
      b_req <= '0;
      due <= 1'b0;
      repeat (4) @(posedge aclk);
    end
    @(posedge aclk);
    ecc_enc_data <= {xs(), xs()};
    repeat (2) @(posedge aclk);
    ecc_dec_word <= {ecc_enc_check, ecc_enc_data ^ 64'h10};
    repeat (2) @(negedge aclk);
    chk("ecc_dec_data", 72'(ecc_enc_data), 72'(ecc_dec_data));
    chk("ecc_dec_sbit", 72'h1, 72'(ecc_dec_sbit));
    chk("ecc_dec_dbit", 72'h0, 72'(ecc_dec_dbit));
    sel = 1'b1;
    fq = 1'b1;
    @(posedge aclk);
    wr(8'h00, 32'h0002_0000, 4'hF);
    wr(8'h08, 32'h4, 4'h3);
    wr(8'h04, 32'h0001_0001, 4'hF);
    for (int i = 0; i < 5; i++) begin
      mem[i] = {xs(), xs(), 8'(xs())};
      @(posedge aclk);
      push <= 1'b1;
      data <= mem[i];
    end
    @(posedge aclk);
    push <= 1'b0;
    repeat (3) @(negedge aclk);
    chk("fifo_full", 72'h1, 72'(fifo_full));
    chk("fifo_afull", 72'h1, 72'(fifo_afull));
    chk("fifo_aempty", 72'h0, 72'(fifo_aempty));
    for (int i = 0; i < 5; i++) begin
      @(posedge aclk);
      pop <= 1'b1;
      due <= (i < 4);
      if (i < 4) exp_q.push_back(mem[i]);
    end
    @(posedge aclk);
    pop <= 1'b0;
    due <= 1'b0;
    repeat (4) @(negedge aclk);
    chk("fifo_empty", 72'h1, 72'(fifo_empty));
    chk("fifo_full", 72'h0, 72'(fifo_full));
    @(posedge aclk);
    wr(8'h00, 32'h0006_0000, 4'hF);
    @(posedge aclk);
    push <= 1'b1;
    data <= mem[4];
    @(posedge aclk);
    push <= 1'b0;
    repeat (5) @(negedge aclk);
    chk("fifo_dout", mem[4], fifo_dout);
    chk("fifo_empty", 72'h0, 72'(fifo_empty));
    report_and_stop();
  end
endmodule
